// ---- rtl/dmm_pkg.sv ----
// constants, types and state record of the diagnostic monitor
package dmm_pkg;

  // clock and conversion timing
  localparam int CLK_PERIOD_NS     = 5;
  localparam int CONV_INTERVAL_US  = 100;
  localparam int CONV_CYCLES       = CONV_INTERVAL_US * 1000 / CLK_PERIOD_NS;
  localparam int NUM_CH            = 5;
  localparam int SLOT_CNT_W        = 24;

  // measured channels in sampling order
  typedef enum logic [2:0] {
    CH_TEMP = 3'h0,
    CH_AUX  = 3'h1,
    CH_TXMON = 3'h2,
    CH_BIAS = 3'h3,
    CH_RX   = 3'h4
  } dmm_ch_type;

  // auxiliary source codes
  localparam logic [2:0] AUX_SUPPLY_INPUT   = 3'h0;
  localparam logic [2:0] AUX_ANALOG_SUPPLY  = 3'h1;
  localparam logic [2:0] AUX_BIAS_NODE      = 3'h2;
  localparam logic [2:0] AUX_MOD_NODE       = 3'h3;
  localparam logic [2:0] AUX_POWER_LOOP_DAC = 3'h4;
  localparam logic [2:0] AUX_MOD_DAC        = 3'h5;
  localparam logic [2:0] AUX_FAULT_DAC      = 3'h6;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_WAIT = 2'h1
  } dmm_seq_type;

  // diagnostic page offsets
  localparam logic [7:0] OFS_TEMP_HI  = 8'h60;
  localparam logic [7:0] OFS_TEMP_LO  = 8'h61;
  localparam logic [7:0] OFS_AUX      = 8'h62;
  localparam logic [7:0] OFS_BIAS     = 8'h64;
  localparam logic [7:0] OFS_TXMON    = 8'h66;
  localparam logic [7:0] OFS_RX_HI    = 8'h68;
  localparam logic [7:0] OFS_RX_LO    = 8'h69;
  localparam logic [7:0] OFS_ALM_FLAG_LO = 8'h70;
  localparam logic [7:0] OFS_ALM_FLAG_HI = 8'h71;
  localparam logic [7:0] OFS_WRN_FLAG_LO = 8'h74;
  localparam logic [7:0] OFS_WRN_FLAG_HI = 8'h75;
  localparam logic [7:0] OFS_ALARM_MASK_LOW    = 8'hF8;
  localparam logic [7:0] OFS_ALARM_MASK_HIGH   = 8'hF9;
  localparam logic [7:0] OFS_WARNING_MASK_LOW  = 8'hFA;
  localparam logic [7:0] OFS_WARNING_MASK_HIGH = 8'hFB;

  // configuration page offsets
  localparam logic [7:0] OFS_OEM_CONFIG_ZERO = 8'h00;
  localparam logic [7:0] OFS_LUT_BASE        = 8'h60;
  localparam logic [7:0] OFS_LUT_LAST        = 8'h86;

  // configuration field positions
  localparam int CFG_AUX_LSB        = 0;
  localparam int CFG_GAIN_BIT       = 3;
  localparam int CFG_REF_BIT        = 4;
  localparam int CFG_FINE_BIT       = 5;
  localparam int CFG_ALM_TRANSP_BIT = 6;
  localparam int CFG_WRN_TRANSP_BIT = 7;

  // reset values and the used bits of the high mask bytes
  localparam logic [7:0] MASK_LOW_RST  = 8'h00;
  localparam logic [7:0] MASK_HIGH_RST = 8'h40;
  localparam logic [7:0] MASK_HIGH_USED = 8'hC0;
  localparam logic [7:0] CFG_RST       = 8'h00;

  // temperature table
  localparam int         LUT_DEPTH      = 39;
  localparam logic [5:0] LUT_LAST_IDX   = 6'h26;
  localparam int         TEMP_LOW_DEG   = -45;
  localparam int         TEMP_HIGH_DEG  = 104;
  localparam int         TEMP_BIN_BASE  = 44;

  // four flag bytes: alarm low/high, warning low/high
  typedef logic [3:0][7:0] dmm_bytes_type;

  // register request from the management port
  typedef struct packed {
    logic       page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dmm_regreq_type;

  // whole state of the monitor
  typedef struct packed {
    dmm_seq_type              seq;
    logic [2:0]               ch;
    logic [SLOT_CNT_W-1:0]    slot_cnt;
    logic                     adc_start;
    logic [2:0]               adc_ch;
    logic [2:0]               aux_sel;
    logic                     gain;
    logic                     ref_sel;
    logic [7:0]               cfg;
    dmm_bytes_type            mask;
    dmm_bytes_type            flg;
    logic [11:0]              res_temp;
    logic [7:0]               res_aux;
    logic [7:0]               res_tx;
    logic [7:0]               res_bias;
    logic [11:0]              res_rx;
    logic [5:0]               lut_index;
    logic [2:0]               txd_sync;
    logic                     txd_level;
    logic [7:0]               rdata;
    logic                     int_out;
    logic [LUT_DEPTH-1:0][7:0] lut;
  } dmm_state_type;

endpackage

// ---- rtl/dmm_temp_bin.sv ----
// temperature to compensation table entry index
`timescale 1ns/10ps
module dmm_temp_bin
  import dmm_pkg::*;
(
  input  wire logic signed [11:0] temp_half,
  output logic [5:0]              index
);

  logic signed [10:0] deg;
  logic [10:0]        ofs;

  // whole degrees, then clamp and four degree bins
  always_comb begin
    deg = temp_half[11:1];
    ofs = 11'(deg + 11'(TEMP_BIN_BASE));
    if (deg <= 11'(TEMP_LOW_DEG)) begin
      index = 6'h00;
    end else if (deg >= 11'(TEMP_HIGH_DEG)) begin
      index = LUT_LAST_IDX;
    end else begin
      index = 6'(ofs[7:2] + 6'h01);
    end
  end

endmodule

// ---- rtl/dmm_diag_monitor.sv ----
// diagnostic monitor: channel sequencer, temperature table, masked alarm flags
`timescale 1ns/10ps
module dmm_diag_monitor
  import dmm_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire dmm_regreq_type reg_req,
  output logic [7:0]          reg_rdata,
  input  wire logic           adc_done,
  input  wire logic [11:0]    adc_data,
  output logic                adc_start,
  output logic [2:0]          adc_channel,
  output logic [2:0]          aux_source_select,
  output logic                monitor_gain,
  output logic                monitor_reference_select,
  input  wire logic           oem_mode,
  input  wire logic           transmit_disable,
  input  wire dmm_bytes_type  cond,
  output logic                int_out,
  output logic [5:0]          lut_index,
  output logic [11:0]         temperature
);

  localparam int SLOT_CYCLES = CONV_CYCLES_P / NUM_CH;
  localparam logic [SLOT_CNT_W-1:0] SLOT_MAX = SLOT_CNT_W'(SLOT_CYCLES - 1);

  dmm_state_type      st_ff;
  dmm_state_type      nxt_st;
  logic [5:0]         idx_sensed;
  logic [5:0]         idx_comp;
  logic signed [11:0] temp_comp;
  logic [7:0]         lut_ofs;
  logic               txd_toggle;

  // chip to case correction in half degrees
  assign temp_comp = $signed(adc_data) - 12'($signed(st_ff.lut[idx_sensed]));
  assign lut_ofs   = reg_req.addr - OFS_LUT_BASE;

  // bin of the sensed value selects the correction
  dmm_temp_bin u_bin_sensed (
    .temp_half (adc_data),
    .index     (idx_sensed)
  );

  // bin of the corrected value drives the parameter tables
  dmm_temp_bin u_bin_comp (
    .temp_half (temp_comp),
    .index     (idx_comp)
  );

  // next state of the whole monitor
  always_comb begin
    nxt_st = st_ff;
    nxt_st.adc_start = 1'b0;
    txd_toggle = 1'b0;
    // transmit disable synchroniser, toggle once stages two and three agree
    nxt_st.txd_sync = {st_ff.txd_sync[1:0], transmit_disable};
    if ((st_ff.txd_sync[1] == st_ff.txd_sync[2]) &&
        (st_ff.txd_sync[2] != st_ff.txd_level)) begin
      txd_toggle = 1'b1;
      nxt_st.txd_level = st_ff.txd_sync[2];
    end
    // slot divider, five slots per conversion interval
    if (st_ff.slot_cnt == SLOT_MAX) begin
      nxt_st.slot_cnt = '0;
    end else begin
      nxt_st.slot_cnt = st_ff.slot_cnt + 1'b1;
    end
    // channel sequencer
    case (st_ff.seq)
      SEQ_IDLE: begin
        if (st_ff.slot_cnt == SLOT_MAX) begin
          nxt_st.adc_start = 1'b1;
          nxt_st.adc_ch    = st_ff.ch;
          nxt_st.aux_sel   = oem_mode ? st_ff.cfg[CFG_AUX_LSB+:3] : AUX_SUPPLY_INPUT;
          nxt_st.gain      = st_ff.cfg[CFG_GAIN_BIT];
          nxt_st.ref_sel   = st_ff.cfg[CFG_REF_BIT];
          nxt_st.seq       = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (adc_done) begin
          case (st_ff.ch)
            CH_TEMP: begin
              nxt_st.res_temp  = st_ff.cfg[CFG_FINE_BIT] ? temp_comp
                                                         : {temp_comp[11:1], 1'b0};
              nxt_st.lut_index = idx_comp;
            end
            CH_AUX:   nxt_st.res_aux  = adc_data[7:0];
            CH_TXMON: nxt_st.res_tx   = adc_data[7:0];
            CH_BIAS:  nxt_st.res_bias = adc_data[7:0];
            default:  nxt_st.res_rx   = adc_data;
          endcase
          nxt_st.ch  = (st_ff.ch == CH_RX) ? CH_TEMP : 3'(st_ff.ch + 3'h1);
          nxt_st.seq = SEQ_IDLE;
        end
      end
      default: nxt_st.seq = SEQ_IDLE;
    endcase
    // register writes
    if (reg_req.wr) begin
      if (!reg_req.page) begin
        case (reg_req.addr)
          OFS_ALARM_MASK_LOW:    nxt_st.mask[0] = reg_req.wdata;
          OFS_ALARM_MASK_HIGH:   nxt_st.mask[1] = reg_req.wdata & MASK_HIGH_USED;
          OFS_WARNING_MASK_LOW:  nxt_st.mask[2] = reg_req.wdata;
          OFS_WARNING_MASK_HIGH: nxt_st.mask[3] = reg_req.wdata & MASK_HIGH_USED;
          default: ;
        endcase
      end else if (reg_req.addr == OFS_OEM_CONFIG_ZERO) begin
        nxt_st.cfg = reg_req.wdata;
      end else if (reg_req.addr >= OFS_LUT_BASE && reg_req.addr <= OFS_LUT_LAST) begin
        nxt_st.lut[lut_ofs[5:0]] = reg_req.wdata;
      end
    end
    // flags: clear by read or transmit disable toggle, a new event wins
    for (int i = 0; i < 4; i++) begin
      logic       clr;
      logic       transp;
      logic [7:0] used;
      clr    = 1'b0;
      transp = (i < 2) ? st_ff.cfg[CFG_ALM_TRANSP_BIT] : st_ff.cfg[CFG_WRN_TRANSP_BIT];
      used   = i[0] ? MASK_HIGH_USED : 8'hFF;
      if (reg_req.rd && !reg_req.page) begin
        clr = (i == 0 && reg_req.addr == OFS_ALM_FLAG_LO) ||
              (i == 1 && reg_req.addr == OFS_ALM_FLAG_HI) ||
              (i == 2 && reg_req.addr == OFS_WRN_FLAG_LO) ||
              (i == 3 && reg_req.addr == OFS_WRN_FLAG_HI);
      end
      if (transp) begin
        nxt_st.flg[i] = cond[i] & used;
      end else begin
        nxt_st.flg[i] = ((clr || txd_toggle) ? 8'h00 : st_ff.flg[i]) | (cond[i] & used);
      end
    end
    // interrupt from unmasked flags
    nxt_st.int_out = |(nxt_st.flg & ~nxt_st.mask);
    // read data
    if (reg_req.rd) begin
      nxt_st.rdata = 8'h00;
      if (!reg_req.page) begin
        case (reg_req.addr)
          OFS_TEMP_HI:           nxt_st.rdata = st_ff.res_temp[11:4];
          OFS_TEMP_LO:           nxt_st.rdata = {st_ff.res_temp[3:0], 4'h0};
          OFS_AUX:               nxt_st.rdata = st_ff.res_aux;
          OFS_BIAS:              nxt_st.rdata = st_ff.res_bias;
          OFS_TXMON:             nxt_st.rdata = st_ff.res_tx;
          OFS_RX_HI:             nxt_st.rdata = st_ff.res_rx[11:4];
          OFS_RX_LO:             nxt_st.rdata = {st_ff.res_rx[3:0], 4'h0};
          OFS_ALM_FLAG_LO:       nxt_st.rdata = st_ff.flg[0];
          OFS_ALM_FLAG_HI:       nxt_st.rdata = st_ff.flg[1];
          OFS_WRN_FLAG_LO:       nxt_st.rdata = st_ff.flg[2];
          OFS_WRN_FLAG_HI:       nxt_st.rdata = st_ff.flg[3];
          OFS_ALARM_MASK_LOW:    nxt_st.rdata = st_ff.mask[0];
          OFS_ALARM_MASK_HIGH:   nxt_st.rdata = st_ff.mask[1];
          OFS_WARNING_MASK_LOW:  nxt_st.rdata = st_ff.mask[2];
          OFS_WARNING_MASK_HIGH: nxt_st.rdata = st_ff.mask[3];
          default: ;
        endcase
      end else if (reg_req.addr == OFS_OEM_CONFIG_ZERO) begin
        nxt_st.rdata = st_ff.cfg;
      end else if (reg_req.addr >= OFS_LUT_BASE && reg_req.addr <= OFS_LUT_LAST) begin
        nxt_st.rdata = st_ff.lut[lut_ofs[5:0]];
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff         <= '0;
      st_ff.seq     <= SEQ_IDLE;
      st_ff.cfg     <= CFG_RST;
      st_ff.mask[0] <= MASK_LOW_RST;
      st_ff.mask[1] <= MASK_HIGH_RST;
      st_ff.mask[2] <= MASK_LOW_RST;
      st_ff.mask[3] <= MASK_HIGH_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata                = st_ff.rdata;
  assign adc_start                = st_ff.adc_start;
  assign adc_channel              = st_ff.adc_ch;
  assign aux_source_select        = st_ff.aux_sel;
  assign monitor_gain             = st_ff.gain;
  assign monitor_reference_select = st_ff.ref_sel;
  assign int_out                  = st_ff.int_out;
  assign lut_index                = st_ff.lut_index;
  assign temperature              = st_ff.res_temp;

  // masks come out of reset at their defaults
  property p_mask_reset;
    @(posedge clk) !rstn |=> (st_ff.mask == {MASK_HIGH_RST, MASK_LOW_RST,
                                            MASK_HIGH_RST, MASK_LOW_RST});
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask reset value wrong");

  // interrupt agrees with unmasked flags in the same cycle
  property p_int_or;
    @(posedge clk) disable iff (!rstn) $past(rstn) |-> (int_out == |(st_ff.flg & ~st_ff.mask));
  endproperty
  a_int_or: assert property (p_int_or) else $error("interrupt not OR of unmasked flags");

  // an unmasked condition raises the interrupt next cycle
  property p_unmasked_sets;
    @(posedge clk) disable iff (!rstn)
      (|(cond & ~st_ff.mask & {MASK_HIGH_USED, 8'hFF, MASK_HIGH_USED, 8'hFF}) && !reg_req.wr)
      |=> int_out;
  endproperty
  a_unmasked_sets: assert property (p_unmasked_sets) else $error("unmasked event lost");

  // after the received power result the sequence wraps to temperature
  property p_next_channel;
    @(posedge clk) disable iff (!rstn)
      (st_ff.seq == SEQ_WAIT && adc_done && st_ff.ch == CH_RX) |=>
      (st_ff.ch == CH_TEMP && st_ff.seq == SEQ_IDLE);
  endproperty
  a_next_channel: assert property (p_next_channel) else $error("channel order broken");

  // outside OEM mode the aux slot samples the supply input
  property p_aux_default;
    @(posedge clk) disable iff (!rstn) (st_ff.seq == SEQ_IDLE && st_ff.slot_cnt == SLOT_MAX
      && st_ff.ch == CH_AUX && !oem_mode) |=> (adc_start && aux_source_select == AUX_SUPPLY_INPUT);
  endproperty
  a_aux_default: assert property (p_aux_default) else $error("aux source not supply input");

  // latched flags hold without clear
  property p_flag_hold;
    @(posedge clk) disable iff (!rstn) (!st_ff.cfg[CFG_ALM_TRANSP_BIT] && !reg_req.rd && !txd_toggle)
      |=> ((st_ff.flg[0] & $past(st_ff.flg[0])) == $past(st_ff.flg[0]));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("latched alarm flag dropped");

  // a read of the alarm flag byte clears it when idle
  property p_read_clear;
    @(posedge clk) disable iff (!rstn) (reg_req.rd && !reg_req.page && reg_req.addr == OFS_ALM_FLAG_LO
      && cond[0] == 8'h00) |=> (st_ff.flg[0] == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

  // table index stays within 39 entries
  property p_index_range;
    @(posedge clk) disable iff (!rstn) lut_index <= LUT_LAST_IDX;
  endproperty
  a_index_range: assert property (p_index_range) else $error("table index out of range");

  // reserved mask bits never stick
  property p_mask_reserved;
    @(posedge clk) disable iff (!rstn) ##1 (st_ff.mask[1][5:0] == 6'h00 && st_ff.mask[3][5:0] == 6'h00);
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("reserved mask bit set");

  // oem mode copies the configured source at each start
  property p_oem_source;
    @(posedge clk) disable iff (!rstn)
      (st_ff.seq == SEQ_IDLE && st_ff.slot_cnt == SLOT_MAX && oem_mode && !reg_req.wr)
      |=> (aux_source_select == st_ff.cfg[CFG_AUX_LSB+:3]);
  endproperty
  a_oem_source: assert property (p_oem_source) else $error("aux not from config");

  // gain and reference follow the configuration at each start
  property p_monitor_bits;
    @(posedge clk) disable iff (!rstn)
      (st_ff.seq == SEQ_IDLE && st_ff.slot_cnt == SLOT_MAX && !reg_req.wr)
      |=> (monitor_gain == st_ff.cfg[CFG_GAIN_BIT]
           && monitor_reference_select == st_ff.cfg[CFG_REF_BIT]);
  endproperty
  a_monitor_bits: assert property (p_monitor_bits) else $error("gain or ref lost");

  // received power keeps all twelve bits
  property p_rx_result;
    @(posedge clk) disable iff (!rstn)
      (st_ff.seq == SEQ_WAIT && adc_done && st_ff.ch == CH_RX) |=>
      (st_ff.res_rx == $past(adc_data));
  endproperty
  a_rx_result: assert property (p_rx_result) else $error("rx result cut");

  // nothing unmasked pending keeps the interrupt low
  property p_masked_quiet;
    @(posedge clk) disable iff (!rstn)
      (!(|(st_ff.flg & ~st_ff.mask)) && !(|(cond & ~st_ff.mask)) && !reg_req.wr)
      |=> !int_out;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked int raised");

  // a settled transmit disable change clears all idle flags
  property p_txd_clear;
    @(posedge clk) disable iff (!rstn) (txd_toggle && cond == '0) |=> (st_ff.flg == '0);
  endproperty
  a_txd_clear: assert property (p_txd_clear) else $error("toggle kept a flag");

endmodule

// ---- verification/dmm_adc_model.sv ----
// converter model answering the monitor's conversion starts
`timescale 1ns/10ps
module dmm_adc_model
  import dmm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             adc_start,
  input  wire logic [2:0]       adc_channel,
  input  wire logic [3:0]       delay,
  input  wire logic [4:0][11:0] vals,
  output logic                  adc_done,
  output logic [11:0]           adc_data
);
  logic       busy_ff;
  logic [3:0] cnt_ff;
  logic [2:0] ch_ff;

  // one conversion per start, answered after a chosen delay
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= 4'h0;
      ch_ff    <= 3'h0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;                 // data not held outside the done pulse
      if (adc_start) begin
        busy_ff <= 1'b1;
        ch_ff   <= adc_channel;
        cnt_ff  <= delay;
      end else if (busy_ff) begin
        if (cnt_ff == 4'h0) begin
          adc_done <= 1'b1;
          adc_data <= vals[ch_ff];           // full 12 bit result
          busy_ff  <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
    end
  end
endmodule

// ---- verification/test_dmm_diag_monitor.sv ----
// self-checking bench for the diagnostic monitor
`timescale 1ns/10ps
module test_dmm_diag_monitor
  import dmm_pkg::*;
;
  localparam int CONV_P = 50;
  logic             clk;
  logic             rstn;
  dmm_regreq_type   reg_req;
  logic [7:0]       reg_rdata;
  logic             adc_done;
  logic [11:0]      adc_data;
  logic             adc_start;
  logic [2:0]       adc_channel;
  logic [2:0]       aux_source_select;
  logic             monitor_gain;
  logic             monitor_reference_select;
  logic             oem_mode;
  logic             transmit_disable;
  dmm_bytes_type    cond;
  logic             int_out;
  logic [5:0]       lut_index;
  logic [11:0]      temperature;
  logic [3:0]       delay;
  logic [4:0][11:0] vals;
  logic [2:0]       starts[$];
  int               fail_count = 0;
  int               compares = 0;

  dmm_diag_monitor #(.CONV_CYCLES_P(CONV_P)) dut (
    .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
    .adc_channel(adc_channel), .aux_source_select(aux_source_select),
    .monitor_gain(monitor_gain), .monitor_reference_select(monitor_reference_select),
    .oem_mode(oem_mode), .transmit_disable(transmit_disable), .cond(cond),
    .int_out(int_out), .lut_index(lut_index), .temperature(temperature)
  );
  dmm_adc_model adc (
    .clk(clk), .rstn(rstn), .adc_start(adc_start), .adc_channel(adc_channel),
    .delay(delay), .vals(vals), .adc_done(adc_done), .adc_data(adc_data)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // record channel of every conversion start
  always @(posedge clk) begin
    if (rstn && adc_start === 1'b1) begin
      starts.push_back(adc_channel);
    end
  end

  task automatic cmp(input logic [11:0] seen, input logic [11:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_req <= '{page: page, addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
  endtask

  task automatic rd_cmp(input logic page, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    reg_req <= '{page: page, addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1;
    cmp(reg_rdata, exp, $sformatf("read %h", addr));
  endtask

  // one-cycle condition pulse, then let flag and interrupt settle
  task automatic pulse_cond(input int b, input int i);
    @(posedge clk);
    cond[b][i] <= 1'b1;
    @(posedge clk);
    cond <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_start(input logic [2:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(adc_start === 1'b1 && adc_channel === ch) && n < 200);
    if (n >= 200) cmp(12'h000, 12'h001, "no conversion start");
  endtask

  function automatic int temp_bin(input int t);
    if (t <= -45) return 0;
    if (t >= 104) return 38;
    return (t + 44) / 4 + 1;
  endfunction

  task automatic test_masks();
    rd_cmp(1'b0, OFS_ALARM_MASK_LOW, 8'h00);
    rd_cmp(1'b0, OFS_ALARM_MASK_HIGH, 8'h40);
    rd_cmp(1'b0, OFS_WARNING_MASK_LOW, 8'h00);
    rd_cmp(1'b0, OFS_WARNING_MASK_HIGH, 8'h40);
    reg_wr(1'b0, OFS_ALARM_MASK_LOW, 8'hA5);
    rd_cmp(1'b0, OFS_ALARM_MASK_LOW, 8'hA5);
    reg_wr(1'b0, OFS_WARNING_MASK_LOW, 8'h5A);
    rd_cmp(1'b0, OFS_WARNING_MASK_LOW, 8'h5A);
    reg_wr(1'b0, OFS_ALARM_MASK_HIGH, 8'hFF);
    rd_cmp(1'b0, OFS_ALARM_MASK_HIGH, 8'hC0);
    reg_wr(1'b0, OFS_WARNING_MASK_HIGH, 8'h3F);
    rd_cmp(1'b0, OFS_WARNING_MASK_HIGH, 8'h00);
    rd_cmp(1'b0, 8'h10, 8'h00);
    reg_wr(1'b0, OFS_ALARM_MASK_LOW, 8'h00);
    reg_wr(1'b0, OFS_ALARM_MASK_HIGH, 8'h40);
    reg_wr(1'b0, OFS_WARNING_MASK_LOW, 8'h00);
    reg_wr(1'b0, OFS_WARNING_MASK_HIGH, 8'h40);
    $display("test masks done");
  endtask

  task automatic test_flags();
    pulse_cond(0, 7);
    cmp(int_out, 1'b1, "int unmasked");
    repeat (5) @(posedge clk);
    #1;
    cmp(int_out, 1'b1, "int held");
    rd_cmp(1'b0, OFS_ALM_FLAG_LO, 8'h80);
    cmp(int_out, 1'b0, "int after read");
    rd_cmp(1'b0, OFS_ALM_FLAG_LO, 8'h00);
    reg_wr(1'b0, OFS_ALARM_MASK_LOW, 8'h01);
    pulse_cond(0, 0);
    cmp(int_out, 1'b0, "int masked");
    reg_wr(1'b0, OFS_ALARM_MASK_LOW, 8'h00);
    #1;
    cmp(int_out, 1'b1, "int unmasked latch");
    rd_cmp(1'b0, OFS_ALM_FLAG_LO, 8'h01);
    pulse_cond(1, 6);
    cmp(int_out, 1'b0, "rx low masked");
    pulse_cond(1, 7);
    cmp(int_out, 1'b1, "rx high alarm");
    rd_cmp(1'b0, OFS_ALM_FLAG_HI, 8'hC0);
    pulse_cond(2, 0);
    cmp(int_out, 1'b1, "warning low byte");
    rd_cmp(1'b0, OFS_WRN_FLAG_LO, 8'h01);
    pulse_cond(3, 6);
    cmp(int_out, 1'b0, "rx low warning");
    pulse_cond(3, 7);
    cmp(int_out, 1'b1, "rx high warning");
    @(posedge clk);
    transmit_disable <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    cmp(int_out, 1'b0, "int after toggle");
    rd_cmp(1'b0, OFS_WRN_FLAG_HI, 8'h00);
    reg_wr(1'b1, OFS_OEM_CONFIG_ZERO, 8'h40);
    @(posedge clk);
    cond[0][5] <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    cmp(int_out, 1'b1, "transparent alarm");
    @(posedge clk);
    cond <= '0;
    repeat (2) @(posedge clk);
    #1;
    cmp(int_out, 1'b0, "transparent follows");
    reg_wr(1'b1, OFS_OEM_CONFIG_ZERO, 8'h00);
    $display("test flags done");
  endtask

  task automatic test_sequence();
    wait_start(CH_TEMP);
    starts.delete();
    repeat (CONV_P) @(posedge clk);
    #1;
    cmp(12'(starts.size()), 12'd5, "starts per interval");
    for (int i = 0; i < 5; i++) begin
      cmp(12'(starts[i]), 12'(i), "channel order");
    end
    $display("test sequence done");
  endtask

  task automatic test_aux();
    logic [2:0] code;
    @(posedge clk);
    oem_mode <= 1'b1;
    for (int c = 0; c < 7; c++) begin
      code = 3'(c);
      reg_wr(1'b1, OFS_OEM_CONFIG_ZERO, {3'b000, code[1], code[0], code});
      wait_start(CH_AUX);
      cmp(aux_source_select, code, "aux source");
      cmp(monitor_gain, code[0], "gain");
      cmp(monitor_reference_select, code[1], "ref");
    end
    @(posedge clk);
    oem_mode <= 1'b0;
    wait_start(CH_AUX);
    cmp(aux_source_select, 3'h0, "aux without oem");
    $display("test aux done");
  endtask

  task automatic test_temp();
    int sensed[5] = '{100, -90, -88, 208, 206};
    int corr[5] = '{90, -90, -88, 208, 206};
    reg_wr(1'b1, OFS_OEM_CONFIG_ZERO, 8'h20);
    reg_wr(1'b1, OFS_LUT_BASE + 8'h18, 8'h0A); // five degrees stored doubled
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      vals[0] <= 12'(sensed[k]);
      vals[4] <= 12'hABC;
      wait_start(CH_TEMP);
      wait_start(CH_TEMP);
      repeat (8) @(posedge clk);
      #1;
      cmp(temperature, 12'(corr[k]), "compensated temp");
      cmp(lut_index, 12'(temp_bin(corr[k] / 2)), "table bin");
    end
    reg_wr(1'b1, OFS_OEM_CONFIG_ZERO, 8'h00);
    @(posedge clk);
    vals[0] <= 12'h065;
    wait_start(CH_TEMP);
    wait_start(CH_TEMP);
    repeat (8) @(posedge clk);
    #1;
    cmp(temperature, 12'h05A, "whole degree temp");
    cmp(lut_index, 12'h017, "whole degree bin");
    rd_cmp(1'b0, OFS_RX_HI, 8'hAB);
    rd_cmp(1'b0, OFS_RX_LO, 8'hC0);
    $display("test temp done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    reg_req = '0;
    oem_mode = 1'b0;
    transmit_disable = 1'b0;
    cond = '0;
    delay = 4'h3;
    vals = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    test_masks();
    test_flags();
    test_sequence();
    test_aux();
    test_temp();
    final_report();
  end
endmodule
